// ===== rtl/scab_bridge.sv
`timescale 1ns/100ps
// How it works
// - Command holds byte enables in bits 19:16
// - Each enable bit gates one data byte
// - Software sets all enables before stepping modes
// - Command bits 15:0 hold target address
// - High MAC at 1F0h, low 16 bits
// - Low MAC at 1F4h, full word, read/write
// - Pause frames use the 48-bit MAC
// - Loader fills high MAC from bytes 05h,06h
// - Loader fills low bytes 0,3 from 01h,04h
// - Loader copies bytes into host MAC too
// - High and low MAC bus writes accepted after initialization only, host MAC keeps loader bytes
// - Write-only window decoded from 200h to 2DCh
// - Window write sets address, enables, write, busy
// - Busy clears when the fabric access finishes
// - Window answers reads with zero only
// - Window value reset zero, forwarded as data
// - Command bit 31 busy, starts access
// - Command bit 30 selects read or write
module scab_bridge (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_ce,
   input wire logic [scab_pkg::AXI_ADDR_W-1:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [scab_pkg::DATA_W-1:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [scab_pkg::AXI_ADDR_W-1:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [scab_pkg::DATA_W-1:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   input wire logic i_ee_byte_valid,
   input wire logic [7:0] i_ee_byte_addr,
   input wire logic [7:0] i_ee_byte_data,
   input wire logic i_init_done,
   output logic [47:0] o_pause_mac,
   output logic [15:0] o_host_mac_address_high,
   output logic [31:0] o_host_mac_address_low,
   scab_fabric_if.bridge fab
);
   import scab_pkg::*;
   // ****************************************************************
   // State and write decode
   // ****************************************************************
   logic aw_held_q;
   logic w_held_q;
   logic [AXI_ADDR_W-1:0] aw_addr_q;
   logic [DATA_W-1:0] w_data_q;
   logic [3:0] w_strb_q;
   logic busy_q;
   logic dir_q;
   logic [BE_W-1:0] be_q;
   logic [FAB_ADDR_W-1:0] addr_q;
   logic [DATA_W-1:0] data_q;
   logic [15:0] mac_high_q;
   logic [31:0] mac_low_q;
   logic wr_fire;
   logic hit_cmd;
   logic hit_data;
   logic hit_high;
   logic hit_low;
   logic hit_win;
   logic [AXI_ADDR_W-1:0] win_ofs;
   logic [DATA_W-1:0] cmd_word;
   logic [DATA_W-1:0] cmd_new;
   logic [DATA_W-1:0] rd_word;
   logic rd_known;
   // Address match on word boundaries
   assign wr_fire = aw_held_q && w_held_q && !o_bvalid;
   assign hit_cmd = aw_addr_q[11:2] == OFS_CMD[11:2];
   assign hit_data = aw_addr_q[11:2] == OFS_DATA[11:2];
   assign hit_high = aw_addr_q[11:2] == OFS_MAC_HIGH[11:2];
   assign hit_low = aw_addr_q[11:2] == OFS_MAC_LOW[11:2];
   assign hit_win = aw_addr_q >= OFS_WIN_FIRST && aw_addr_q <= (OFS_WIN_LAST | 12'h003);
   assign win_ofs = aw_addr_q - OFS_WIN_FIRST;
   assign cmd_word = {busy_q, dir_q, 10'h000, be_q, addr_q};
   assign cmd_new = scab_merge(cmd_word, w_data_q, w_strb_q);
   // Register read mux, window reads zero
   always_comb
   begin
      rd_word = DATA_RESET;
      rd_known = 1'b1;
      if (i_araddr[11:2] == OFS_CMD[11:2])
         rd_word = cmd_word;
      else if (i_araddr[11:2] == OFS_DATA[11:2])
         rd_word = data_q;
      else if (i_araddr[11:2] == OFS_MAC_HIGH[11:2])
         rd_word = {16'h0000, mac_high_q};
      else if (i_araddr[11:2] == OFS_MAC_LOW[11:2])
         rd_word = mac_low_q;
      else if (i_araddr >= OFS_WIN_FIRST && i_araddr <= (OFS_WIN_LAST | 12'h003))
         rd_word = DATA_RESET;
      else
         rd_known = 1'b0;
   end

   // ****************************************************************
   // Bus slave channels
   // ****************************************************************
   // Write address, data and response
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         o_awready <= 1'b1;
         o_wready <= 1'b1;
         o_bvalid <= 1'b0;
         o_bresp <= RESP_OKAY;
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         aw_addr_q <= '0;
         w_data_q <= DATA_RESET;
         w_strb_q <= 4'h0;
      end
      else if (i_ce)
      begin
         if (i_awvalid && o_awready)
         begin
            aw_addr_q <= i_awaddr;
            aw_held_q <= 1'b1;
            o_awready <= 1'b0;
         end
         if (i_wvalid && o_wready)
         begin
            w_data_q <= i_wdata;
            w_strb_q <= i_wstrb;
            w_held_q <= 1'b1;
            o_wready <= 1'b0;
         end
         if (wr_fire)
         begin
            o_bvalid <= 1'b1;
            o_bresp <= (hit_cmd || hit_data || hit_high || hit_low || hit_win) ? RESP_OKAY : RESP_SLVERR;
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
         end
         else if (o_bvalid && i_bready)
         begin
            o_bvalid <= 1'b0;
            o_awready <= 1'b1;
            o_wready <= 1'b1;
         end
      end
   end

   // Read address and data
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         o_arready <= 1'b1;
         o_rvalid <= 1'b0;
         o_rdata <= DATA_RESET;
         o_rresp <= RESP_OKAY;
      end
      else if (i_ce)
      begin
         if (i_arvalid && o_arready)
         begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b1;
            o_rdata <= rd_word;
            o_rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
         end
         else if (o_rvalid && i_rready)
         begin
            o_rvalid <= 1'b0;
            o_arready <= 1'b1;
         end
      end
   end

   // ****************************************************************
   // Fabric access command
   // ****************************************************************
   // Command fields and data, changes ignored while busy
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         busy_q <= 1'b0;
         dir_q <= DIR_WRITE;
         be_q <= BE_RESET;
         addr_q <= ADDR_RESET;
         data_q <= DATA_RESET;
      end
      else if (i_ce)
      begin
         if (busy_q && fab.access_done)
         begin
            busy_q <= 1'b0;
            if (dir_q == DIR_READ)
               data_q <= fab.access_read_data;
         end
         else if (wr_fire && !busy_q)
         begin
            if (hit_cmd)
            begin
               busy_q <= cmd_new[CMD_BUSY_BIT];
               dir_q <= cmd_new[CMD_DIR_BIT];
               be_q <= cmd_new[CMD_BE_LSB +: BE_W];
               addr_q <= cmd_new[CMD_ADDR_LSB +: FAB_ADDR_W];
            end
            else if (hit_data)
               data_q <= scab_merge(data_q, w_data_q, w_strb_q);
            else if (hit_win)
            begin
               addr_q <= scab_win_target(win_ofs[7:2]);
               be_q <= BE_ALL;
               dir_q <= DIR_WRITE;
               busy_q <= 1'b1;
               data_q <= scab_merge(data_q, w_data_q, w_strb_q);
            end
         end
      end
   end

   // ****************************************************************
   // MAC address registers
   // ****************************************************************
   // Loader bytes into switch and host copies, host writes after initialization, pause source
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         mac_high_q <= MAC_HIGH_RESET;
         mac_low_q <= MAC_LOW_RESET;
         o_host_mac_address_high <= MAC_HIGH_RESET;
         o_host_mac_address_low <= MAC_LOW_RESET;
         o_pause_mac <= {MAC_HIGH_RESET, MAC_LOW_RESET};
      end
      else if (i_ce)
      begin
         o_pause_mac <= {mac_high_q, mac_low_q};
         if (i_ee_byte_valid)
         begin
            unique case (i_ee_byte_addr)
               EE_LOW_B0: {o_host_mac_address_low[7:0], mac_low_q[7:0]} <= {2{i_ee_byte_data}};
               EE_LOW_B1: {o_host_mac_address_low[15:8], mac_low_q[15:8]} <= {2{i_ee_byte_data}};
               EE_LOW_B2: {o_host_mac_address_low[23:16], mac_low_q[23:16]} <= {2{i_ee_byte_data}};
               EE_LOW_B3: {o_host_mac_address_low[31:24], mac_low_q[31:24]} <= {2{i_ee_byte_data}};
               EE_HIGH_B0: {o_host_mac_address_high[7:0], mac_high_q[7:0]} <= {2{i_ee_byte_data}};
               EE_HIGH_B1: {o_host_mac_address_high[15:8], mac_high_q[15:8]} <= {2{i_ee_byte_data}};
               default: ;
            endcase
         end
         else if (wr_fire && i_init_done && hit_high)
            mac_high_q <= 16'(scab_merge({16'h0000, mac_high_q}, w_data_q, w_strb_q));
         else if (wr_fire && i_init_done && hit_low)
            mac_low_q <= scab_merge(mac_low_q, w_data_q, w_strb_q);
      end
   end

   // Fabric request straight from command state
   assign fab.access_in_progress = busy_q;
   assign fab.access_direction = dir_q;
   assign fab.fabric_target_address = addr_q;
   assign fab.fabric_byte_enables = be_q;
   assign fab.access_write_data = data_q;
endmodule : scab_bridge

// ===== rtl/scab_pkg.sv
// ****************************************************************
// Shared constants for the fabric access bridge
// ****************************************************************
package scab_pkg;
   localparam int unsigned AXI_ADDR_W = 12;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned FAB_ADDR_W = 16;
   localparam int unsigned BE_W = 4;
   localparam int unsigned WIN_IDX_W = 6;

   // Register byte offsets
   localparam logic [AXI_ADDR_W-1:0] OFS_CMD = 12'h1e8;
   localparam logic [AXI_ADDR_W-1:0] OFS_DATA = 12'h1ec;
   localparam logic [AXI_ADDR_W-1:0] OFS_MAC_HIGH = 12'h1f0;
   localparam logic [AXI_ADDR_W-1:0] OFS_MAC_LOW = 12'h1f4;
   localparam logic [AXI_ADDR_W-1:0] OFS_WIN_FIRST = 12'h200;
   localparam logic [AXI_ADDR_W-1:0] OFS_WIN_LAST = 12'h2dc;

   // Command field positions
   localparam int unsigned CMD_BUSY_BIT = 31;
   localparam int unsigned CMD_DIR_BIT = 30;
   localparam int unsigned CMD_BE_LSB = 16;
   localparam int unsigned CMD_ADDR_LSB = 0;

   // Values after reset, plus all-enables and direction codes
   localparam logic [15:0] MAC_HIGH_RESET = 16'hffff;
   localparam logic [31:0] MAC_LOW_RESET = 32'hff0f8000;
   localparam logic [FAB_ADDR_W-1:0] ADDR_RESET = 16'h0000;
   localparam logic [BE_W-1:0] BE_RESET = 4'h0;
   localparam logic [BE_W-1:0] BE_ALL = 4'hf;
   localparam logic [DATA_W-1:0] DATA_RESET = 32'h00000000;
   localparam logic DIR_WRITE = 1'b0;
   localparam logic DIR_READ = 1'b1;

   // Loader byte addresses
   localparam logic [7:0] EE_LOW_B0 = 8'h01;
   localparam logic [7:0] EE_LOW_B1 = 8'h02;
   localparam logic [7:0] EE_LOW_B2 = 8'h03;
   localparam logic [7:0] EE_LOW_B3 = 8'h04;
   localparam logic [7:0] EE_HIGH_B0 = 8'h05;
   localparam logic [7:0] EE_HIGH_B1 = 8'h06;

   // Bus answers
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // Direct window map
   localparam logic [15:0] WIN_GEN0_ADDR = 16'h0001;
   localparam logic [15:0] WIN_GEN1_ADDR = 16'h0004;
   localparam logic [15:0] WIN_PORT_STRIDE = 16'h0400;
   localparam logic [15:0] WIN_PORT_OFS0 = 16'h0001;
   localparam logic [15:0] WIN_PORT_OFS1 = 16'h0040;
   localparam logic [15:0] WIN_PORT_OFS2 = 16'h0041;
   localparam logic [15:0] WIN_PORT_OFS3 = 16'h0080;
   localparam logic [WIN_IDX_W-1:0] WIN_PORT_FIRST = 6'h02;
   localparam logic [WIN_IDX_W-1:0] WIN_PORT_END = 6'h0e;
   localparam logic [15:0] WIN_SPARE_BASE = 16'hf000;

   // Fabric address for one window word
   function automatic logic [15:0] scab_win_target(input logic [WIN_IDX_W-1:0] idx);
      logic [WIN_IDX_W-1:0] k;
      logic [15:0] port;
      logic [15:0] ofs;
      k = idx - WIN_PORT_FIRST;
      port = {12'h000, k[5:2]} + 16'h0001;
      unique case (k[1:0])
         2'b00: ofs = WIN_PORT_OFS0;
         2'b01: ofs = WIN_PORT_OFS1;
         2'b10: ofs = WIN_PORT_OFS2;
         default: ofs = WIN_PORT_OFS3;
      endcase
      if (idx == 6'h00)
         return WIN_GEN0_ADDR;
      if (idx == 6'h01)
         return WIN_GEN1_ADDR;
      if (idx < WIN_PORT_END)
         return 16'((port * WIN_PORT_STRIDE) | ofs);
      return WIN_SPARE_BASE | {10'h000, idx};
   endfunction : scab_win_target

   // Byte-lane merge, one enable bit per data byte
   function automatic logic [DATA_W-1:0] scab_merge(input logic [DATA_W-1:0] old_word,
         input logic [DATA_W-1:0] new_word, input logic [BE_W-1:0] be);
      logic [DATA_W-1:0] res;
      res = old_word;
      for (int b = 0; b < BE_W; b++)
      begin
         if (be[b])
            res[b*8 +: 8] = new_word[b*8 +: 8];
      end
      return res;
   endfunction : scab_merge
endpackage : scab_pkg

// ===== rtl/scab_fabric_if.sv
`timescale 1ns/100ps
// ****************************************************************
// Link between bridge and fabric register space
// ****************************************************************
interface scab_fabric_if;
   logic access_in_progress;
   logic access_direction;
   logic [15:0] fabric_target_address;
   logic [3:0] fabric_byte_enables;
   logic [31:0] access_write_data;
   logic access_done;
   logic [31:0] access_read_data;

   modport bridge (output access_in_progress, output access_direction, output fabric_target_address,
      output fabric_byte_enables, output access_write_data, input access_done, input access_read_data);
   modport fabric (input access_in_progress, input access_direction, input fabric_target_address,
      input fabric_byte_enables, input access_write_data, output access_done, output access_read_data);
endinterface : scab_fabric_if

// ===== rtl/scab_fabric.sv
`timescale 1ns/100ps
// ****************************************************************
// Fabric register space end
// ****************************************************************
module scab_fabric #(
   parameter int unsigned FAB_WORDS = 16
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_ce,
   scab_fabric_if.fabric fab,
   input wire logic [$clog2(FAB_WORDS)-1:0] i_peek_index,
   output logic [scab_pkg::DATA_W-1:0] o_peek_data
);
   import scab_pkg::*;

   localparam int unsigned IDX_W = $clog2(FAB_WORDS);

   logic [DATA_W-1:0] mem_q [FAB_WORDS];
   logic done_q;
   logic [DATA_W-1:0] rdata_q;
   logic [IDX_W-1:0] idx;
   logic take;

   // Word select and one access per request
   assign idx = fab.fabric_target_address[IDX_W-1:0];
   assign take = fab.access_in_progress && !done_q;

   // Completion pulse and read capture
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         done_q <= 1'b0;
         rdata_q <= DATA_RESET;
      end
      else if (i_ce)
      begin
         done_q <= take;
         if (take && fab.access_direction == DIR_READ)
            rdata_q <= mem_q[idx];
      end
   end

   // Storage with byte-gated writes
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         for (int i = 0; i < FAB_WORDS; i++)
            mem_q[i] <= DATA_RESET;
      end
      else if (i_ce)
      begin
         if (take && fab.access_direction == DIR_WRITE)
            mem_q[idx] <= scab_merge(mem_q[idx], fab.access_write_data, fab.fabric_byte_enables);
      end
   end

   // User-side observation port
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         o_peek_data <= DATA_RESET;
      else if (i_ce)
         o_peek_data <= mem_q[i_peek_index];
   end

   assign fab.access_done = done_q;
   assign fab.access_read_data = rdata_q;
endmodule : scab_fabric

// ===== sim/scab_link_asserts.sv
`timescale 1ns/100ps
// ****************************************************************
// Fabric link checks
// ****************************************************************
module scab_link_asserts (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic access_in_progress,
   input wire logic access_direction,
   input wire logic [15:0] fabric_target_address,
   input wire logic [3:0] fabric_byte_enables,
   input wire logic [31:0] access_write_data,
   input wire logic access_done,
   input wire logic [31:0] access_read_data
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_reset_n);

   // Start, completion and hold of one fabric access
   property p_done_after_start;
      $rose(access_in_progress) |=> access_done;
   endproperty
   a_done_after_start: assert property (p_done_after_start) else $error("no completion after start");
   property p_busy_clears;
      access_done |=> !access_in_progress;
   endproperty
   a_busy_clears: assert property (p_busy_clears) else $error("busy kept after completion");
   property p_done_in_busy;
      access_done |-> access_in_progress;
   endproperty
   a_done_in_busy: assert property (p_done_in_busy) else $error("completion without access");
   property p_done_pulse;
      access_done |=> !access_done;
   endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("completion longer than one cycle");
   property p_busy_two;
      $rose(access_in_progress) |-> access_in_progress[*2] ##1 !access_in_progress;
   endproperty
   a_busy_two: assert property (p_busy_two) else $error("busy length wrong");
   property p_req_stable;
      access_in_progress && $past(access_in_progress) |-> $stable(fabric_target_address)
         && $stable(fabric_byte_enables) && $stable(access_direction) && $stable(access_write_data);
   endproperty
   a_req_stable: assert property (p_req_stable) else $error("request moved while busy");
   property p_rdata_hold;
      !access_in_progress && !$past(access_in_progress) |-> $stable(access_read_data);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved while idle");
   property p_reset_clean;
      $rose(i_reset_n) |-> !access_in_progress && !access_done && !access_direction
         && fabric_target_address == 16'h0000 && fabric_byte_enables == 4'h0;
   endproperty
   a_reset_clean: assert property (p_reset_clean) else $error("link not clear after reset");
endmodule : scab_link_asserts

// ===== sim/scab_bridge_tb_top.sv
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
// ****************************************************************
// Bridge and fabric bench
// ****************************************************************
module scab_bridge_tb_top;
   import scab_pkg::*;
   typedef struct {logic rd; logic [1:0] resp; logic [31:0] data;} scab_exp_s;
   logic i_clk = 0, i_reset_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic ee_v = 0, init_done = 0, ce = 1, awready, wready, bvalid, arready, rvalid;
   logic [11:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, peek_data, hmac_l, lo, d;
   logic [3:0] wstrb = 0, peek_idx = 0, be;
   logic [7:0] ee_a = 0, ee_d = 0, eb [8];
   logic [1:0] bresp, rresp;
   logic [47:0] pause_mac;
   logic [15:0] hmac_h, hi, a, t;
   logic [31:0] rng = 32'h39b81fd6, mem [16] = '{default: 32'h0};
   int error_cnt = 0, checked = 0, wl [8] = '{0, 1, 2, 5, 9, 13, 14, 55};
   scab_exp_s expq [$], e;

   scab_fabric_if link ();
   scab_bridge scab_bridge_i (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_ce(ce), .i_awaddr(awaddr),
      .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid),
      .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
      .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
      .i_rready(rready), .i_ee_byte_valid(ee_v), .i_ee_byte_addr(ee_a), .i_ee_byte_data(ee_d),
      .i_init_done(init_done), .o_pause_mac(pause_mac), .o_host_mac_address_high(hmac_h),
      .o_host_mac_address_low(hmac_l), .fab(link));
   scab_fabric #(.FAB_WORDS(16)) scab_fabric_i (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_ce(ce),
      .fab(link), .i_peek_index(peek_idx), .o_peek_data(peek_data));
   scab_link_asserts scab_link_asserts_i (.i_clk(i_clk), .i_reset_n(i_reset_n),
      .access_in_progress(link.access_in_progress), .access_direction(link.access_direction),
      .fabric_target_address(link.fabric_target_address), .fabric_byte_enables(link.fabric_byte_enables),
      .access_write_data(link.access_write_data), .access_done(link.access_done),
      .access_read_data(link.access_read_data));

   // Clock, 100 ns period
   initial
   begin
      forever #50 i_clk = ~i_clk;
   end

   function automatic logic [31:0] nxt();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction : nxt

   // Byte-lane merge of the bench
   function automatic logic [31:0] mrg(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
      for (int b = 0; b < 4; b++)
         if (s[b])
            o[b*8 +: 8] = n[b*8 +: 8];
      return o;
   endfunction : mrg

   // Fabric address of one window word
   function automatic logic [15:0] win_tgt(input int i);
      logic [15:0] ofs [4] = '{16'h0001, 16'h0040, 16'h0041, 16'h0080};
      if (i < 2)
         return (i == 0) ? 16'h0001 : 16'h0004;
      if (i < 14)
         return 16'((i - 2) / 4 + 1) * 16'h0400 | ofs[(i - 2) % 4];
      return 16'hf000 | 16'(i);
   endfunction : win_tgt

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : tally_and_finish

   task automatic wr(input logic [11:0] ad, input logic [31:0] dt, input logic [3:0] s, input logic [1:0] r);
      logic ah, wh, bh;
      expq.push_back('{1'b0, r, 32'h0});
      @(posedge i_clk);
      awaddr <= ad;
      wdata <= dt;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int n = 0; n < 40; n++)
      begin
         @(negedge i_clk);
         ah = awvalid & awready;
         wh = wvalid & wready;
         bh = bvalid & bready;
         @(posedge i_clk);
         if (ah)
            awvalid <= 1'b0;
         if (wh)
            wvalid <= 1'b0;
         if (bh)
         begin
            bready <= 1'b0;
            return;
         end
      end
      error_cnt++;
      tally_and_finish();
   endtask : wr

   task automatic rd(input logic [11:0] ad, input logic [31:0] dt, input logic [1:0] r);
      logic ah, rh;
      expq.push_back('{1'b1, r, dt});
      @(posedge i_clk);
      araddr <= ad;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int n = 0; n < 40; n++)
      begin
         @(negedge i_clk);
         ah = arvalid & arready;
         rh = rvalid & rready;
         @(posedge i_clk);
         if (ah)
            arvalid <= 1'b0;
         if (rh)
         begin
            rready <= 1'b0;
            return;
         end
      end
      error_cnt++;
      tally_and_finish();
   endtask : rd

   task automatic idle();
      for (int n = 0; n < 20; n++)
      begin
         @(negedge i_clk);
         if (link.access_in_progress === 1'b0)
            return;
      end
      error_cnt++;
      tally_and_finish();
   endtask : idle

   task automatic peek(input logic [15:0] fa);
      @(posedge i_clk);
      peek_idx <= fa[3:0];
      repeat (2) @(posedge i_clk);
      @(negedge i_clk);
      `CHK(peek_data, mem[fa[3:0]])
   endtask : peek

   task automatic ee(input logic [7:0] ba, input logic [7:0] bd);
      @(posedge i_clk);
      ee_v <= 1'b1;
      ee_a <= ba;
      ee_d <= bd;
      @(posedge i_clk);
      ee_v <= 1'b0;
   endtask : ee

   // Compares each bus answer with the oldest note
   always @(negedge i_clk)
   begin
      if ((bvalid & bready) | (rvalid & rready))
      begin
         if (expq.size() > 0)
            e = expq.pop_front();
         else
            e = '{1'bx, 2'bxx, 32'hx};
         `CHK({rvalid, rvalid ? {rresp, rdata} : {bresp, 32'h0}}, {e.rd, e.resp, e.data})
      end
   end

   // Main sequence
   initial
   begin
      repeat (4) @(posedge i_clk);
      i_reset_n <= 1'b1;
      @(negedge i_clk);
      `CHK(pause_mac, 48'hffff_ff0f8000)
      `CHK({hmac_h, hmac_l}, 48'hffff_ff0f8000)
      rd(OFS_MAC_HIGH, 32'h0000ffff, RESP_OKAY);
      rd(OFS_MAC_LOW, 32'hff0f8000, RESP_OKAY);
      wr(OFS_MAC_LOW, 32'h12345678, 4'hf, RESP_OKAY);
      rd(OFS_MAC_LOW, 32'hff0f8000, RESP_OKAY);
      wr(12'h100, 32'h1, 4'hf, RESP_SLVERR);
      rd(12'h100, 32'h0, RESP_SLVERR);
      rd(12'h2e0, 32'h0, RESP_SLVERR);
      $display("test reset and refusals done");
      for (int i = 1; i < 8; i++)
      begin
         eb[i] = 8'(nxt());
         ee(8'(i), eb[i]);
      end
      ce <= 1'b0;
      ee(8'h01, ~eb[1]);
      ce <= 1'b1;
      lo = {eb[4], eb[3], eb[2], eb[1]};
      hi = {eb[6], eb[5]};
      rd(OFS_MAC_HIGH, {16'h0, hi}, RESP_OKAY);
      rd(OFS_MAC_LOW, lo, RESP_OKAY);
      `CHK({hmac_h, hmac_l}, {hi, lo})
      `CHK(pause_mac, {hi, lo})
      init_done <= 1'b1;
      d = nxt();
      t = d[15:0];
      wr(OFS_MAC_HIGH, d, 4'hf, RESP_OKAY);
      rd(OFS_MAC_HIGH, {16'h0, t}, RESP_OKAY);
      d = nxt();
      wr(OFS_MAC_LOW, d, 4'b0101, RESP_OKAY);
      rd(OFS_MAC_LOW, mrg(lo, d, 4'b0101), RESP_OKAY);
      `CHK(pause_mac, {t, mrg(lo, d, 4'b0101)})
      `CHK({hmac_h, hmac_l}, {hi, lo})
      $display("test mac registers done");
      for (int i = 0; i < 6; i++)
      begin
         a = 16'(nxt());
         d = nxt();
         be = 4'(nxt());
         wr(OFS_DATA, d, 4'hf, RESP_OKAY);
         wr(OFS_CMD, {2'b10, 10'h0, be, a}, 4'hf, RESP_OKAY);
         idle();
         mem[a[3:0]] = mrg(mem[a[3:0]], d, be);
         peek(a);
         rd(OFS_CMD, {2'b00, 10'h0, be, a}, RESP_OKAY);
         wr(OFS_CMD, {2'b11, 10'h0, 4'hf, a}, 4'hf, RESP_OKAY);
         idle();
         rd(OFS_DATA, mem[a[3:0]], RESP_OKAY);
         rd(OFS_CMD, {2'b01, 10'h0, 4'hf, a}, RESP_OKAY);
      end
      $display("test indirect access done");
      foreach (wl[i])
      begin
         t = win_tgt(wl[i]);
         d = nxt();
         wr(12'h200 + 12'(wl[i] * 4), d, 4'hf, RESP_OKAY);
         idle();
         mem[t[3:0]] = d;
         peek(t);
         rd(OFS_CMD, {16'h000f, t}, RESP_OKAY);
         rd(12'h200 + 12'(wl[i] * 4), 32'h0, RESP_OKAY);
      end
      $display("test direct window done");
      tally_and_finish();
   end
endmodule : scab_bridge_tb_top
